// ===== logic/sbc_pkg.sv
// System bus cycle unit: shared constants, register map and state codes.
// Assumes a 50 MHz system clock and a bus clock of half that rate.
package sbc_pkg;
  localparam int          CLK_HZ          = 50_000_000;
  localparam int          BUS_CLK_HZ      = 25_000_000;
  localparam int          BUS_DIV         = CLK_HZ / BUS_CLK_HZ;
  // Wishbone register byte offsets
  localparam logic [7:0]  ADR_DCFG        = 8'h00;
  localparam logic [7:0]  ADR_ISTAT       = 8'h04;
  localparam logic [7:0]  ADR_BSTAT       = 8'h08;
  // data_config_reg fields
  localparam int          DCFG_WC_LSB     = 0;
  localparam int          DCFG_SYNC_BIT   = 2;
  localparam int          DCFG_LBR_BIT    = 3;
  localparam int          DCFG_RSEL_BIT   = 4;
  localparam int          DCFG_W          = 5;
  localparam logic [4:0]  DCFG_RST        = 5'h00;
  // irq_status_reg fields
  localparam int          ISTAT_RETRY_BIT = 0;
  // Slave timing, in bus clocks
  localparam logic [3:0]  SLV_GRANT_IDLE  = 4'h1;
  localparam logic [3:0]  SLV_GRANT_MSTR  = 4'h5;
  localparam logic [3:0]  SLV_DATA_DELAY  = 4'h2;
  localparam int          NSYNC           = 14;
  // Pins idle after reset, so no false strobe or select follows it
  localparam logic [13:0] PIN_RST         = 14'h1f00;

  typedef enum logic [6:0] {
    M_IDLE  = 7'b0000001,
    M_REQ   = 7'b0000010,
    M_T1    = 7'b0000100,
    M_TW    = 7'b0001000,
    M_T2    = 7'b0010000,
    M_TH    = 7'b0100000,
    M_RWAIT = 7'b1000000
  } sbc_mst_t;

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_DELAY = 5'b00010,
    S_GRANT = 5'b00100,
    S_ACK   = 5'b01000,
    S_END   = 5'b10000
  } sbc_slv_t;
endpackage

// ===== logic/sbc_cycle_unit.sv
// System bus cycle unit: little-endian master memory cycles, bus retry,
// big-endian slave register cycles, Wishbone configuration registers.
// Assumes DMA requests from the same clock; pins come from outside.
//
// Behaviour
// RULE1 - T1 asserts strobes, address held whole cycle
// RULE2 - Sync mode: ready sampled ending T2, repeat
// RULE3 - Sync: read captured ending T2, write driven
// RULE4 - Async: ready sampled falling T1 and T2
// RULE5 - Async: cycle ends 1.5 clocks after sample
// RULE6 - Async read: strobe falling T1, capture falling T2
// RULE7 - Async write: strobe only when waits exist
// RULE8 - Async: strobe released falling final T2
// RULE9 - Ready early in T1 gives two-clock cycle
// RULE10 - Retry ends cycle, releases the bus
// RULE11 - Without latching, retry same cycle again
// RULE12 - Latched retry waits flag clear, input release
// RULE13 - Retry beats every normal termination
// RULE14 - Retry sampling sync or async, async-mode only
// RULE15 - Host holds retry past hold state
// RULE16 - Slave cycle needs strobe then chip select
// RULE17 - Idle: grant one clock after capture
// RULE18 - Master: grant five clocks plus waits
// RULE19 - Read data with grant, write two later
// RULE20 - Both acks low two clocks after grant
// RULE21 - Release on strobe or select deassert
// RULE22 - Host spacing between select and request
// RULE23 - Programmed waits; terminations ignored meanwhile
// RULE24 - Endian select picks pin functions
// RULE25 - Termination mode latched per cycle start
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module sbc_cycle_unit
  import sbc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Internal DMA side
  input  wire logic        dma_req_i,
  input  wire logic        dma_we_i,
  input  wire logic [22:0] dma_addr_i,
  input  wire logic [2:0]  dma_status_i,
  input  wire logic [15:0] dma_wdata_i,
  output logic      [15:0] dma_rdata_o,
  output logic             dma_done_o,
  // Bus pins
  output logic             bus_clk_o,
  output logic      [22:0] addr_o,
  output logic      [2:0]  bus_cycle_status_o,
  output logic             master_write_dir_o,
  output logic             addr_strobe_n_o,
  output logic             early_cycle_start_n_o,
  output logic             data_strobe_n_o,
  input  wire logic [15:0] data_i,
  output logic      [15:0] data_o,
  output logic             data_oe_o,
  input  wire logic        ready_in_n_i,
  input  wire logic        sync_terminate_n_i,
  input  wire logic        retry_request_n_i,
  output logic             bus_request_out_o,
  input  wire logic        bus_grant_i,
  output logic             grant_ack_out_n_o,
  input  wire logic        endian_bus_sel_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        slave_addr_strobe_n_i,
  input  wire logic        slave_rw_dir_i,
  input  wire logic [5:0]  reg_index_i,
  output logic             slave_mem_grant_n_o,
  output logic      [1:0]  cycle_ack_pair_n_o,
  output logic             cycle_ack_oe_o
);

  // Pin synchronisers: three stages, change taken when stages 2 and 3 agree
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic [NSYNC-1:0] s3_r;
  logic [NSYNC-1:0] pin_r;

  assign pin_raw = {bus_grant_i, sync_terminate_n_i, ready_in_n_i, retry_request_n_i, chip_select_n_i,
                    slave_addr_strobe_n_i, slave_rw_dir_i, endian_bus_sel_i, reg_index_i};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1_r[gi]  <= PIN_RST[gi];
          s2_r[gi]  <= PIN_RST[gi];
          s3_r[gi]  <= PIN_RST[gi];
          pin_r[gi] <= PIN_RST[gi];
        end else begin
          s1_r[gi] <= pin_raw[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            pin_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate

  logic       grant_f;
  logic       sync_terminate_f;
  logic       ready_f;
  logic       retry_f;
  logic       cs_f;
  logic       sas_f;
  logic       srw_f;
  logic       big_end_f;
  logic [5:0] ra_f;

  assign grant_f   = pin_r[13];
  assign sync_terminate_f   = ~pin_r[12];
  assign ready_f   = ~pin_r[11];
  assign retry_f   = ~pin_r[10];
  assign cs_f      = ~pin_r[9];
  assign sas_f     = ~pin_r[8];
  assign srw_f     = pin_r[7];
  assign big_end_f = pin_r[6];
  assign ra_f      = pin_r[5:0];

  // Bus clock phase: rise_en starts a bus state, fall_en marks its middle
  logic ph_r;
  logic rise_en;
  logic fall_en;

  assign rise_en = ph_r;
  assign fall_en = ~ph_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_r      <= 1'b0;
      bus_clk_o <= 1'b0;
    end else begin
      ph_r      <= ~ph_r;
      bus_clk_o <= rise_en;
    end
  end

  // Configuration and status registers
  logic [DCFG_W-1:0] dcfg_r;
  logic              retry_flag_r;
  logic              retry_evt;
  logic              wb_req;
  logic [1:0]        wc_cfg;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wc_cfg = dcfg_r[DCFG_WC_LSB +: 2];

  sbc_mst_t   mst_r;
  sbc_slv_t   slv_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      dcfg_r   <= DCFG_RST;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i && wb_adr_i == ADR_DCFG && wb_sel_i[0]) begin
        dcfg_r <= wb_dat_i[DCFG_W-1:0];
      end
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          ADR_DCFG:  wb_dat_o <= {27'h0, dcfg_r};
          ADR_ISTAT: wb_dat_o <= {31'h0, retry_flag_r};
          ADR_BSTAT: wb_dat_o <= {20'h0, slv_r, mst_r};
          default:   wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Retry flag: write one to clear; a new retry in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      retry_flag_r <= 1'b0;
    end else if (retry_evt) begin
      retry_flag_r <= 1'b1;
    end else if (wb_req && wb_we_i && wb_adr_i == ADR_ISTAT && wb_sel_i[0] && wb_dat_i[ISTAT_RETRY_BIT]) begin
      retry_flag_r <= 1'b0;
    end
  end

  // Master cycle sequencer
  logic       sync_mode_r;
  logic       async_rt_r;
  logic [1:0] wc_r;
  logic [1:0] wait_left_r;
  logic       rdy_seen_r;
  logic       fin_r;
  logic       retry_seen_r;
  logic       we_r;
  logic [15:0] wdata_r;
  logic       retry_hit;
  logic       gnt_low_r;
  logic       term_in;
  logic       slv_pend;
  logic       cyc_end;
  logic       mst_busy;

  assign slv_pend  = (slv_r != S_IDLE);
  assign mst_busy  = (mst_r == M_T1) || (mst_r == M_TW) || (mst_r == M_T2);
  // Big-endian termination comes only from the synchronous terminate pin
  assign term_in   = big_end_f ? sync_terminate_f : ready_f; // RULE24
  assign retry_hit = async_rt_r ? (retry_seen_r | retry_f) : retry_f; // RULE14
  assign retry_evt = rise_en && mst_r == M_T2 && retry_hit;
  assign cyc_end   = rise_en && mst_r == M_T2 && !retry_hit && (sync_mode_r ? term_in : fin_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mst_r                 <= M_IDLE;
      sync_mode_r           <= 1'b0;
      async_rt_r            <= 1'b0;
      wc_r                  <= 2'h0;
      wait_left_r           <= 2'h0;
      fin_r                 <= 1'b0;
      we_r                  <= 1'b0;
      wdata_r               <= 16'h0000;
      addr_o                <= 23'h000000;
      bus_cycle_status_o    <= 3'h0;
      master_write_dir_o    <= 1'b0;
      addr_strobe_n_o       <= 1'b1;
      early_cycle_start_n_o <= 1'b1;
    end else if (rise_en) begin
      unique case (mst_r)
        M_IDLE: begin
          if (dma_req_i && !slv_pend) begin
            mst_r <= M_REQ;
          end
        end
        M_REQ: begin
          if (grant_f && gnt_low_r && !slv_pend) begin
            mst_r                 <= M_T1;
            sync_mode_r           <= dcfg_r[DCFG_SYNC_BIT]; // RULE25
            async_rt_r            <= dcfg_r[DCFG_RSEL_BIT] & ~dcfg_r[DCFG_SYNC_BIT]; // RULE14
            wc_r                  <= wc_cfg;
            we_r                  <= dma_we_i;
            wdata_r               <= dma_wdata_i;
            addr_o                <= dma_addr_i; // RULE1
            bus_cycle_status_o    <= dma_status_i;
            master_write_dir_o    <= dma_we_i;
            addr_strobe_n_o       <= 1'b0; // RULE1
            early_cycle_start_n_o <= 1'b0;
          end else if (!dma_req_i || slv_pend) begin
            mst_r <= M_IDLE;
          end
        end
        M_T1: begin
          addr_strobe_n_o <= 1'b1; // RULE1
          wait_left_r     <= wc_r;
          fin_r           <= rdy_seen_r;
          mst_r           <= (wc_r != 2'h0) ? M_TW : M_T2; // RULE23
        end
        M_TW: begin
          wait_left_r <= wait_left_r - 2'h1;
          fin_r       <= rdy_seen_r;
          if (wait_left_r == 2'h1) begin
            mst_r <= M_T2;
          end
        end
        M_T2: begin
          if (retry_hit) begin
            mst_r <= M_TH; // RULE10 RULE13
          end else if (cyc_end) begin
            mst_r <= M_IDLE; // RULE2 RULE5
          end else begin
            fin_r <= rdy_seen_r; // RULE4
          end
        end
        M_TH: begin
          mst_r <= dcfg_r[DCFG_LBR_BIT] ? M_RWAIT : M_REQ; // RULE11
        end
        M_RWAIT: begin
          if (!retry_flag_r && !retry_f) begin
            mst_r <= M_REQ; // RULE12
          end
        end
        default: mst_r <= M_IDLE;
      endcase
    end else if (mst_r == M_T1) begin
      early_cycle_start_n_o <= 1'b1; // RULE1
    end
  end

  // Grant must drop after a cycle; a stale synchronised grant would skip arbitration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gnt_low_r <= 1'b0;
    end else if (mst_r == M_T1) begin
      gnt_low_r <= 1'b0;
    end else if (!grant_f) begin
      gnt_low_r <= 1'b1; // RULE10
    end
  end

  // Asynchronous ready and retry samples, taken at falling edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_seen_r   <= 1'b0;
      retry_seen_r <= 1'b0;
    end else if (rise_en && mst_r == M_REQ) begin
      rdy_seen_r   <= 1'b0;
      retry_seen_r <= 1'b0;
    end else if (fall_en && !sync_mode_r) begin
      // Terminations count only once the programmed waits are spent
      if ((mst_r == M_T1 && wc_r == 2'h0) || (mst_r == M_TW && wait_left_r == 2'h1) || mst_r == M_T2) begin
        rdy_seen_r <= term_in; // RULE4 RULE23
      end
      if (mst_busy && retry_f) begin
        retry_seen_r <= 1'b1; // RULE14
      end
    end
  end

  // Bus ownership follows the sequencer one clock later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_request_out_o <= 1'b0;
      grant_ack_out_n_o <= 1'b1;
    end else begin
      bus_request_out_o <= (mst_r == M_REQ) || mst_busy; // RULE10
      grant_ack_out_n_o <= ~mst_busy;
    end
  end

  // Data strobe and master read capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_strobe_n_o <= 1'b1;
      dma_rdata_o     <= 16'h0000;
      dma_done_o      <= 1'b0;
    end else begin
      dma_done_o <= cyc_end;
      if (cyc_end && sync_mode_r && !we_r) begin
        dma_rdata_o <= data_i; // RULE3
      end
      if (retry_evt) begin
        data_strobe_n_o <= 1'b1;
      end else if (fall_en && !sync_mode_r) begin
        unique case (mst_r)
          M_T1: begin
            if (!we_r) begin
              data_strobe_n_o <= 1'b0; // RULE6
            end
          end
          M_TW: begin
            data_strobe_n_o <= 1'b0; // RULE7
          end
          M_T2: begin
            if (fin_r) begin
              data_strobe_n_o <= 1'b1; // RULE8
              if (!we_r) begin
                dma_rdata_o <= data_i; // RULE6
              end
            end else begin
              data_strobe_n_o <= 1'b0; // RULE7
            end
          end
          default: data_strobe_n_o <= 1'b1;
        endcase
      end
    end
  end

  // Slave register access, big-endian pin mode only
  logic [15:0] slv_mem [0:63];
  logic [3:0]  slv_cnt_r;
  logic        cs_on;
  logic        slv_write_take;

  assign cs_on          = cs_f && sas_f && big_end_f; // RULE16 RULE24
  assign slv_write_take = fall_en && slv_r == S_GRANT && slv_cnt_r == 4'h1 && cs_on && !srw_f;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slv_r               <= S_IDLE;
      slv_cnt_r           <= 4'h0;
      slave_mem_grant_n_o <= 1'b1;
      cycle_ack_pair_n_o  <= 2'b11;
      cycle_ack_oe_o      <= 1'b0;
    end else begin
      cycle_ack_oe_o <= big_end_f; // RULE24
      unique case (slv_r)
        S_IDLE: begin
          if (fall_en && cs_on) begin
            slv_r     <= S_DELAY;
            // Wait states of a running master cycle stretch the grant
            slv_cnt_r <= mst_busy ? (SLV_GRANT_MSTR + {2'h0, wc_r}) : SLV_GRANT_IDLE; // RULE17 RULE18
          end
        end
        S_DELAY: begin
          if (!cs_on) begin
            slv_r <= S_END;
          end else if (fall_en) begin
            if (slv_cnt_r == 4'h1 && !mst_busy) begin
              slave_mem_grant_n_o <= 1'b0; // RULE17 RULE18
              slv_cnt_r           <= SLV_DATA_DELAY;
              slv_r               <= S_GRANT;
            end else if (slv_cnt_r != 4'h1) begin
              slv_cnt_r <= slv_cnt_r - 4'h1;
            end
          end
        end
        S_GRANT: begin
          if (!cs_on) begin
            slave_mem_grant_n_o <= 1'b1; // RULE21
            slv_r               <= S_END;
          end else if (fall_en) begin
            if (slv_cnt_r == 4'h1) begin
              cycle_ack_pair_n_o <= 2'b00; // RULE20
              slv_r              <= S_ACK;
            end else begin
              slv_cnt_r <= slv_cnt_r - 4'h1;
            end
          end
        end
        S_ACK: begin
          if (!cs_on) begin
            slave_mem_grant_n_o <= 1'b1; // RULE21
            cycle_ack_pair_n_o  <= 2'b11;
            slv_r               <= S_END;
          end
        end
        S_END: begin
          // A new access needs the address strobe or the chip select to drop
          if (!sas_f || !cs_f) begin
            slv_r <= S_IDLE;
          end
        end
        default: slv_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (slv_write_take) begin
      slv_mem[ra_f] <= data_i; // RULE19
    end
  end

  // Shared data pins: master write data or slave read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_o    <= 16'h0000;
      data_oe_o <= 1'b0;
    end else if (slv_r == S_DELAY && fall_en && slv_cnt_r == 4'h1 && !mst_busy && cs_on && srw_f) begin
      data_o    <= slv_mem[ra_f]; // RULE19
      data_oe_o <= 1'b1;
    end else if ((slv_r == S_GRANT || slv_r == S_ACK) && !cs_on) begin
      data_oe_o <= 1'b0; // RULE21
    end else if (fall_en && mst_r == M_T1 && we_r) begin
      data_o    <= wdata_r; // RULE3 RULE7
      data_oe_o <= 1'b1;
    end else if (rise_en && mst_r == M_T2 && (retry_hit || cyc_end)) begin
      data_oe_o <= 1'b0; // RULE3
    end
  end

endmodule // sbc_cycle_unit

// ===== bench/sbc_cycle_unit_properties.sv
// Checker: pin timing of the cycle unit, master strobes and slave handshake.
// Assumes it is bound onto sbc_cycle_unit and sees only that module's ports.
`timescale 1ns/1ns
module sbc_cycle_unit_props (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        bus_clk_o,
  input  wire logic [22:0] addr_o,
  input  wire logic [2:0]  bus_cycle_status_o,
  input  wire logic        master_write_dir_o,
  input  wire logic        addr_strobe_n_o,
  input  wire logic        early_cycle_start_n_o,
  input  wire logic        data_strobe_n_o,
  input  wire logic        bus_request_out_o,
  input  wire logic        grant_ack_out_n_o,
  input  wire logic        data_oe_o,
  input  wire logic        endian_bus_sel_i,
  input  wire logic        slave_addr_strobe_n_i,
  input  wire logic        slave_rw_dir_i,
  input  wire logic        slave_mem_grant_n_o,
  input  wire logic [1:0]  cycle_ack_pair_n_o,
  input  wire logic        cycle_ack_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ads_ecs_start: assert property ($fell(addr_strobe_n_o) |-> $fell(early_cycle_start_n_o) && bus_clk_o)
    else $error("strobes do not open the cycle together");
  a_ecs_half: assert property ($fell(early_cycle_start_n_o) |=> early_cycle_start_n_o)
    else $error("early start held past half a state");
  a_ads_width: assert property ($fell(addr_strobe_n_o) |=> !addr_strobe_n_o ##1 addr_strobe_n_o)
    else $error("address strobe not one bus state wide");
  a_addr_held: assert property (!$stable({addr_o, bus_cycle_status_o, master_write_dir_o})
    |-> $fell(addr_strobe_n_o))
    else $error("address or status changed inside a cycle");
  a_ds_owned: assert property (!data_strobe_n_o |-> !grant_ack_out_n_o && bus_request_out_o)
    else $error("data strobe active while bus not owned");
  a_ack_delay: assert property ($fell(slave_mem_grant_n_o)
    |-> (cycle_ack_pair_n_o == 2'b11) [*4] ##1 (cycle_ack_pair_n_o == 2'b00))
    else $error("slave acks not two bus clocks after grant");
  a_read_grant: assert property ($fell(slave_mem_grant_n_o) && slave_rw_dir_i |-> data_oe_o)
    else $error("slave read data not driven with grant");
  a_release_all: assert property ($rose(slave_mem_grant_n_o) |-> cycle_ack_pair_n_o == 2'b11 && !data_oe_o)
    else $error("grant released apart from acks and data");
  a_release_soon: assert property ($rose(slave_addr_strobe_n_i) && !slave_mem_grant_n_o
    |-> ##[1:8] slave_mem_grant_n_o)
    else $error("grant not released after strobe rose");
  a_little_quiet: assert property ((!endian_bus_sel_i) [*8] |-> !cycle_ack_oe_o && slave_mem_grant_n_o)
    else $error("big-endian slave pins active in little-endian mode");
endmodule // sbc_cycle_unit_props

bind sbc_cycle_unit sbc_cycle_unit_props sbc_cycle_unit_props_i (.*);

// ===== bench/sbc_mem_model.sv
// Partner model: bus arbiter and memory beyond the master port.
// Assumes the unit's pin outputs; ready delay and retry come from the bench.
`timescale 1ns/1ns
module sbc_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        addr_strobe_n_i,
  input  wire logic        bus_request_i,
  input  wire logic        write_dir_i,
  input  wire logic        data_oe_i,
  input  wire logic [22:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [3:0]  ready_dly_i,
  input  wire logic        retry_arm_i,
  output logic             ready_n_o = 1'b1,
  output logic             retry_n_o = 1'b1,
  output logic             grant_o = 1'b0,
  output logic      [15:0] rdata_o = 16'h0000,
  output logic      [15:0] last_wr_o = 16'h0000
);
  logic       act_r  = 1'b0;
  logic       used_r = 1'b0;
  logic [3:0] cnt_r  = 4'h0;
  always @(posedge clk_i) begin
    if (rst_i) begin
      act_r <= 1'b0;
      used_r <= 1'b0;
      ready_n_o <= 1'b1;
      retry_n_o <= 1'b1;
      grant_o <= 1'b0;
    end else begin
      grant_o <= bus_request_i;
      act_r <= bus_request_i && (act_r || !addr_strobe_n_i);
      cnt_r <= act_r ? cnt_r + {3'h0, cnt_r != 4'hf} : 4'h0;
      // Zero delay drives ready two clocks after the address strobe falls: shortest cycle
      ready_n_o <= !(act_r && cnt_r >= ready_dly_i);
      if (!retry_arm_i)
        used_r <= 1'b0;
      // Held until the bus is handed back, past the hold state
      if (!retry_n_o && !bus_request_i) begin
        retry_n_o <= 1'b1;
        used_r <= 1'b1;
      end else if (retry_arm_i && !used_r && bus_request_i)
        retry_n_o <= 1'b0;
      if (data_oe_i)
        last_wr_o <= wdata_i;
      // Released lines show a moving pattern, never a stale word
      rdata_o <= (act_r && !write_dir_i) ? (addr_i[15:0] ^ 16'h3c5a) : ~rdata_o;
    end
  end
endmodule // sbc_mem_model

// ===== bench/sbc_cycle_unit_bench.sv
// Testbench: registers, little-endian master cycles in all modes, retry, slave access.
// Assumes the partner model for memory and arbiter; host side driven here.
`timescale 1ns/1ns
module sbc_cycle_unit_bench;
  import sbc_pkg::*;
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf, ready_dly = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, exp_q[$];
  logic        dma_req_i = 0, dma_we_i = 0, dma_done_o, retry_arm = 0, slv_drv = 0, slv_rd = 0;
  logic [22:0] dma_addr_i = 23'h0, addr_o;
  logic [2:0]  dma_status_i = 3'h0, bus_cycle_status_o;
  logic [15:0] dma_wdata_i = 16'h0, dma_rdata_o, data_i, data_o, mem_data, slv_data = 16'h0, last_wr;
  logic [15:0] rnd = 16'h2a86;
  logic        bus_clk_o, master_write_dir_o, addr_strobe_n_o, early_cycle_start_n_o, data_strobe_n_o, data_oe_o;
  logic        ready_in_n_i, retry_request_n_i, bus_request_out_o, bus_grant_i, grant_ack_out_n_o;
  logic        endian_bus_sel_i = 0, chip_select_n_i = 1, slave_addr_strobe_n_i = 1, slave_rw_dir_i = 1;
  logic [5:0]  reg_index_i = 6'h0;
  logic        slave_mem_grant_n_o, cycle_ack_oe_o, sync_terminate_n_i = 1;
  logic [1:0]  cycle_ack_pair_n_o, ack_prev = 2'b11;
  int          err_count = 0, cmp_count = 0, cyc_n = 0, ads_cnt = 0, n = 0, a0 = 0;

  assign data_i = slv_drv ? slv_data : mem_data;
  sbc_cycle_unit sbc_cycle_unit_i (.*);
  sbc_mem_model sbc_mem_model_i (.clk_i(clk_i), .rst_i(rst_i), .addr_strobe_n_i(addr_strobe_n_o),
    .bus_request_i(bus_request_out_o), .write_dir_i(master_write_dir_o), .data_oe_i(data_oe_o),
    .addr_i(addr_o), .wdata_i(data_o), .ready_dly_i(ready_dly), .retry_arm_i(retry_arm),
    .ready_n_o(ready_in_n_i), .retry_n_o(retry_request_n_i), .grant_o(bus_grant_i),
    .rdata_o(mem_data), .last_wr_o(last_wr));

  initial forever #10 clk_i = ~clk_i;
  always @(negedge addr_strobe_n_o) ads_cnt++;

  task end_sim;
    if (exp_q.size() != 0)
      err_count++;
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task take(input string nm, input logic [31:0] s);
    if (exp_q.size() == 0) begin
      err_count++;
      $display("Error %s expected nothing seen %h", nm, s);
    end else
      check(nm, s, exp_q.pop_front());
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_count++;
      end_sim();
    end
  end
  // Result watcher: every result pops the oldest expectation
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && !wb_we_i) take("wb_dat_o", wb_dat_o);
    if (dma_done_o === 1'b1) take("dma_data", {16'h0, dma_we_i ? last_wr : dma_rdata_o});
    if (cycle_ack_pair_n_o === 2'b00 && ack_prev !== 2'b00 && slv_rd) take("slave_data", {16'h0, data_o});
    ack_prev = cycle_ack_pair_n_o;
  end

  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  // Inputs stay fixed until done, so a retried cycle repeats them
  task dma(input logic we);
    rnd = lfsr(rnd);
    exp_q.push_back({16'h0, we ? ~rnd : rnd ^ 16'h3c5a});
    @(posedge clk_i);
    dma_req_i <= 1'b1;
    dma_we_i <= we;
    dma_addr_i <= {rnd[6:0], rnd};
    dma_wdata_i <= ~rnd;
    dma_status_i <= rnd[2:0];
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (dma_done_o !== 1'b1);
    dma_req_i <= 1'b0;
    check("addr_status", {5'h0, master_write_dir_o, bus_cycle_status_o, addr_o}, {5'h0, we, rnd[2:0], rnd[6:0], rnd});
  endtask
  task slv(input logic r, input logic [5:0] ix, input logic [15:0] d);
    if (r) exp_q.push_back({16'h0, d});
    @(posedge clk_i);
    slave_addr_strobe_n_i <= 1'b0;
    slave_rw_dir_i <= r;
    reg_index_i <= ix;
    slv_data <= d;
    slv_drv <= !r;
    slv_rd <= r;
    repeat (2) @(posedge clk_i);
    chip_select_n_i <= 1'b0;
    do @(posedge clk_i); while (cycle_ack_pair_n_o !== 2'b00);
    slave_addr_strobe_n_i <= 1'b1;
    do @(posedge clk_i); while (slave_mem_grant_n_o !== 1'b1);
    chip_select_n_i <= 1'b1;
    slv_drv <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(ADR_DCFG, 32'h0);
    rd(8'h0c, 32'h0);
    wb(1'b1, ADR_BSTAT, 32'hffff_ffff);
    rd(ADR_BSTAT, {20'h0, S_IDLE, M_IDLE});
    // Bit 0 write, bit 1 sync mode, bits 3:2 programmed waits
    for (int m = 0; m < 16; m++) begin
      wb(1'b1, ADR_DCFG, {27'h0, 2'b00, m[1], m[3:2]});
      ready_dly <= rnd[0] ? 4'h0 : 4'h6;
      dma(m[0]);
      check("cycle_len", {31'h0, n >= 2 * (2 + m[3:2])}, 32'h1);
    end
    // Ready held early alongside retry: retry must win
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, ADR_DCFG, {27'h0, k == 2, 1'b0, k == 0, 2'b11});
      ready_dly <= 4'h0;
      retry_arm <= 1'b1;
      a0 = ads_cnt;
      dma(1'b0);
      retry_arm <= 1'b0;
      check("retry_repeat", ads_cnt - a0, 32'h2);
      rd(ADR_ISTAT, 32'h1);
      wb(1'b1, ADR_ISTAT, 32'h1);
      rd(ADR_ISTAT, 32'h0);
    end
    wb(1'b1, ADR_DCFG, {27'h0, 2'b01, 1'b0, 2'b01});
    retry_arm <= 1'b1;
    a0 = ads_cnt;
    fork
      dma(1'b1);
      begin
        repeat (60) @(posedge clk_i);
        check("latched_hold", ads_cnt - a0, 32'h1);
        retry_arm <= 1'b0;
        wb(1'b1, ADR_ISTAT, 32'h1);
      end
    join
    check("latched_retry", ads_cnt - a0, 32'h2);
    rd(ADR_ISTAT, 32'h0);
    endian_bus_sel_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      slv(1'b0, rnd[5:0], rnd ^ 16'ha5a5);
      slv(1'b1, rnd[5:0], rnd ^ 16'ha5a5);
    end
    end_sim();
  end
endmodule // sbc_cycle_unit_bench
